// ===== shared/cfu_pkg.sv
`default_nettype none
package cfu_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned SEL_W = 3;
   localparam int unsigned IMM_W = 7;
   localparam int unsigned LUT_DEPTH = 128;
   localparam int unsigned LUT_AW = 7;
   // operation codes on the 3-bit select field
   localparam logic [2:0] OP_BYTE_SUM = 3'h0;
   localparam logic [2:0] OP_BIN2GRAY = 3'h1;
   localparam logic [2:0] OP_GRAY2BIN = 3'h2;
   localparam logic [2:0] OP_ROTL = 3'h3;
   localparam logic [2:0] OP_MAC = 3'h4;
   localparam logic [2:0] OP_LUT_WR = 3'h5;
   localparam logic [2:0] OP_LUT_RD = 3'h6;
   localparam logic [2:0] OP_MUL = 3'h7;
   localparam logic [5:0] MUL_STEPS = 6'h20;
   localparam logic [31:0] ACC_RESET = 32'h0;
   localparam logic [5:0] CNT_RESET = 6'h0;
   typedef enum logic [3:0] {
      CFU_IDLE = 4'h1,
      CFU_MUL = 4'h2,
      CFU_LUT = 4'h4,
      CFU_DONE = 4'h8
   } cfu_state_t;
endpackage : cfu_pkg
`default_nettype wire

// ===== rtl/cfu_lut_mem.sv
`timescale 1ns/1ps
`default_nettype none
module cfu_lut_mem (
   input wire logic clk,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [cfu_pkg::LUT_AW-1:0] addr,
   input wire logic [cfu_pkg::DATA_W-1:0] wr_data,
   output logic [cfu_pkg::DATA_W-1:0] rd_data
);
   logic [cfu_pkg::DATA_W-1:0] mem [cfu_pkg::LUT_DEPTH];
   always_ff @(posedge clk) begin
      if (ce) begin
         if (wr_en) begin
            mem[addr] <= wr_data;
         end
         rd_data <= mem[addr];
      end
   end
endmodule : cfu_lut_mem
`default_nettype wire

// ===== rtl/cfu_unit.sv
// Functional notes
// RULE_01: cpu reads both source registers and presents them here.
// RULE_02: first operand arrives as 32 bits from first source register.
// RULE_03: second operand arrives as 32 bits from second source register.
// RULE_04: 3-bit select field passes unchanged on its own input.
// RULE_05: 7-bit immediate field passes unchanged on its own input.
// RULE_06: unit decodes the 3-bit select field to pick its operation.
// RULE_07: unit drives a 32-bit result back to the cpu.
// RULE_08: some operations finish combinationally in the start cycle.
// RULE_09: other operations take many cycles and keep state and memory.
// RULE_10: done goes high once the operation has finished.
// RULE_11: cpu waits any duration, no timeout. The cpu model stops waiting after 100 cycles and returns x.
// RULE_12: cpu stays stalled from issue until done.
// RULE_13: cpu defers interrupts while stalled but keeps them queued.
// RULE_14: cpu recognises custom opcode 0001011 in low seven bits.
// RULE_15: cpu never flags illegal instruction for the immediate fields.
// RULE_16: without this extension the custom opcode is illegal.
// RULE_17: cpu writes the result into the destination register.
// RULE_18: one-cycle start per instruction; result valid while done high.
`timescale 1ns/1ps
`default_nettype none
module cfu_unit (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic start,
   input wire logic [cfu_pkg::DATA_W-1:0] first_operand_in,
   input wire logic [cfu_pkg::DATA_W-1:0] second_operand_in,
   input wire logic [cfu_pkg::SEL_W-1:0] op_select_field_in,
   input wire logic [cfu_pkg::IMM_W-1:0] op_immediate_field_in,
   output logic [cfu_pkg::DATA_W-1:0] result,
   output logic done,
   output logic busy
);
   cfu_pkg::cfu_state_t state, next_state;
   logic [31:0] acc, next_acc;
   logic [31:0] res_q, next_res_q;
   logic [31:0] mcand, next_mcand;
   logic [31:0] mplier, next_mplier;
   logic [31:0] prod, next_prod;
   logic [5:0] cnt, next_cnt;
   logic [31:0] mul_ref;
   logic [31:0] comb_res;
   logic [31:0] gray_bin;
   logic [31:0] lut_rd;
   logic lut_we;

   // gray to binary, one xor chain per bit
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_g2b
         assign gray_bin[gi] = ^(first_operand_in >> gi);
      end
   endgenerate

   // single-cycle operations
   always_comb begin
      logic [4:0] amt;
      amt = second_operand_in[4:0];
      comb_res = 32'h0;
      case (op_select_field_in) // RULE_06
         cfu_pkg::OP_BYTE_SUM: comb_res = 32'(first_operand_in[7:0]) +
            32'(first_operand_in[15:8]) + 32'(first_operand_in[23:16]) +
            32'(first_operand_in[31:24]);
         cfu_pkg::OP_BIN2GRAY: comb_res = first_operand_in ^ (first_operand_in >> 1);
         cfu_pkg::OP_GRAY2BIN: comb_res = gray_bin;
         cfu_pkg::OP_ROTL: comb_res = (first_operand_in << amt) |
            (first_operand_in >> (6'h20 - {1'b0, amt}));
         cfu_pkg::OP_MAC: comb_res = acc + first_operand_in * second_operand_in;
         default: comb_res = 32'h0;
      endcase
   end

   assign lut_we = start && (state == cfu_pkg::CFU_IDLE)
      && (op_select_field_in == cfu_pkg::OP_LUT_WR);

   cfu_lut_mem u_lut (
      .clk(clk),
      .ce(ce),
      .wr_en(lut_we),
      .addr(op_immediate_field_in),
      .wr_data(first_operand_in),
      .rd_data(lut_rd)
   );

   always_comb begin
      next_state = state;
      next_acc = acc;
      next_res_q = res_q;
      next_mcand = mcand;
      next_mplier = mplier;
      next_prod = prod;
      next_cnt = cnt;
      case (state)
         cfu_pkg::CFU_IDLE: begin
            if (start) begin // RULE_18
               case (op_select_field_in)
                  cfu_pkg::OP_MUL: begin // RULE_09
                     next_mcand = first_operand_in;
                     next_mplier = second_operand_in;
                     next_prod = 32'h0;
                     next_cnt = cfu_pkg::CNT_RESET;
                     next_state = cfu_pkg::CFU_MUL;
                  end
                  cfu_pkg::OP_LUT_RD, cfu_pkg::OP_LUT_WR: begin
                     next_state = cfu_pkg::CFU_LUT;
                  end
                  default: begin // RULE_08
                     next_res_q = comb_res;
                     if (op_select_field_in == cfu_pkg::OP_MAC) begin
                        next_acc = op_immediate_field_in[0] ? cfu_pkg::ACC_RESET : comb_res;
                     end
                  end
               endcase
            end
         end
         cfu_pkg::CFU_MUL: begin
            if (mplier[0]) begin
               next_prod = prod + mcand;
            end
            next_mcand = mcand << 1;
            next_mplier = mplier >> 1;
            next_cnt = cnt + 6'h1;
            if (cnt == cfu_pkg::MUL_STEPS - 6'h1) begin
               next_state = cfu_pkg::CFU_DONE;
            end
         end
         cfu_pkg::CFU_LUT: begin
            next_res_q = lut_rd;
            next_state = cfu_pkg::CFU_DONE;
         end
         cfu_pkg::CFU_DONE: begin
            next_state = cfu_pkg::CFU_IDLE;
         end
         default: next_state = cfu_pkg::CFU_IDLE;
      endcase
      if (state == cfu_pkg::CFU_MUL && next_state == cfu_pkg::CFU_DONE) begin
         next_res_q = mplier[0] ? prod + mcand : prod;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= cfu_pkg::CFU_IDLE;
         acc <= cfu_pkg::ACC_RESET;
         res_q <= 32'h0;
         mcand <= 32'h0;
         mplier <= 32'h0;
         prod <= 32'h0;
         cnt <= cfu_pkg::CNT_RESET;
      end else if (ce) begin
         state <= next_state;
         acc <= next_acc;
         res_q <= next_res_q;
         mcand <= next_mcand;
         mplier <= next_mplier;
         prod <= next_prod;
         cnt <= next_cnt;
      end
   end

   // combinational ops answer in the start cycle; result flop also held
   always_comb begin
      done = 1'b0;
      result = res_q; // RULE_07
      if (state == cfu_pkg::CFU_IDLE && start && op_select_field_in != cfu_pkg::OP_MUL
          && op_select_field_in != cfu_pkg::OP_LUT_RD
          && op_select_field_in != cfu_pkg::OP_LUT_WR) begin
         done = 1'b1; // RULE_08
         result = comb_res;
      end else if (state == cfu_pkg::CFU_DONE) begin
         done = 1'b1; // RULE_10
      end
   end
   assign busy = (state != cfu_pkg::CFU_IDLE);
   // reference product for the multiply check only
   assign mul_ref = 32'(first_operand_in * second_operand_in);

   sequence s_mul_start;
      start && state == cfu_pkg::CFU_IDLE && op_select_field_in == cfu_pkg::OP_MUL;
   endsequence
   sequence s_mul_finish;
      ##33 (state == cfu_pkg::CFU_DONE && done);
   endsequence

   a_mul_latency: assert property (@(posedge clk) disable iff (!nrst || !ce) // RULE_09
      s_mul_start |-> s_mul_finish)
      else $error("multiply did not finish in 33 cycles");
   a_lut_latency: assert property (@(posedge clk) disable iff (!nrst || !ce) // RULE_09
      (start && state == cfu_pkg::CFU_IDLE && op_select_field_in == cfu_pkg::OP_LUT_RD)
      |-> !done ##1 !done ##1 done)
      else $error("lookup read not done after two cycles");
   a_comb_same: assert property (@(posedge clk) disable iff (!nrst) // RULE_08
      (start && state == cfu_pkg::CFU_IDLE && op_select_field_in == cfu_pkg::OP_BIN2GRAY)
      |-> done && result == (first_operand_in ^ (first_operand_in >> 1)))
      else $error("gray conversion not returned in start cycle");
   a_done_pulse: assert property (@(posedge clk) disable iff (!nrst || !ce) // RULE_10
      (state == cfu_pkg::CFU_DONE) |=> !done || start)
      else $error("done held longer than one cycle");
   a_mul_result: assert property (@(posedge clk) disable iff (!nrst || !ce) // RULE_07
      s_mul_start |-> ##33 result == $past(mul_ref, 33))
      else $error("multiply result wrong");
   a_busy_nodone: assert property (@(posedge clk) disable iff (!nrst) // RULE_18
      (state == cfu_pkg::CFU_MUL || state == cfu_pkg::CFU_LUT) |-> !done)
      else $error("done while still working");
   a_done_only_start: assert property (@(posedge clk) disable iff (!nrst) // RULE_18
      (state == cfu_pkg::CFU_IDLE && !start) |-> !done)
      else $error("done without start");
   a_rot_sel: assert property (@(posedge clk) disable iff (!nrst) // RULE_06
      (start && state == cfu_pkg::CFU_IDLE && op_select_field_in == cfu_pkg::OP_ROTL
       && second_operand_in[4:0] == 5'h0) |-> result == first_operand_in)
      else $error("rotate by zero changed value");
endmodule : cfu_unit
`default_nettype wire

// ===== dv/cfu_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfu_cpu_model (
   input wire logic clk,
   output logic start,
   output logic [cfu_pkg::DATA_W-1:0] op_a,
   output logic [cfu_pkg::DATA_W-1:0] op_b,
   output logic [cfu_pkg::SEL_W-1:0] sel,
   output logic [cfu_pkg::IMM_W-1:0] imm,
   input wire logic [cfu_pkg::DATA_W-1:0] result,
   input wire logic done
);
   // opcode of the custom instruction space, low seven bits
   localparam logic [6:0] CUSTOM_OPC = 7'h0b;
   localparam bit EXT_ON = 1'b1;
   logic illegal_seen;
   initial begin
      start = 1'b0;
      op_a = 32'h0;
      op_b = 32'h0;
      sel = 3'h0;
      imm = 7'h0;
      illegal_seen = 1'b0;
   end
   // bb keeps start up for a following back-to-back issue, only when the op is done in its start cycle (lat 0)
   task automatic issue(input logic [2:0] s, input logic [6:0] m, input logic [31:0] a,
                        input logic [31:0] b, input bit bb, output logic [31:0] res,
                        output int lat);
      logic [31:0] insn;
      insn = {m, 5'h2, 5'h1, s, 5'h3, CUSTOM_OPC};
      // trap on the opcode or on EXT_ON off; immediate fields are never checked
      if (insn[6:0] != CUSTOM_OPC || !EXT_ON) begin
         illegal_seen = 1'b1;
      end
      @(negedge clk);
      start = 1'b1;
      op_a = a;
      op_b = b;
      sel = insn[14:12];
      imm = insn[31:25];
      lat = 0;
      #1;
      // stalled: no interrupt taken here, requests stay pending
      while (done !== 1'b1 && lat < 100) begin
         @(negedge clk);
         start = 1'b0;
         op_a = ~op_a;
         op_b = ~op_b;
         sel = ~sel;
         imm = ~imm;
         lat++;
         #1;
      end
      res = (lat < 100) ? result : 'x;
      if (!bb && start) begin
         @(negedge clk);
         start = 1'b0;
      end
   endtask : issue
endmodule : cfu_cpu_model
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk, nrst, ce, start, done, busy;
   logic [31:0] a, b, result, r;
   logic [2:0] sel;
   logic [6:0] imm;
   int fails, cmp_count, lat;
   cfu_unit dut (.clk(clk), .nrst(nrst), .ce(ce), .start(start), .first_operand_in(a),
      .second_operand_in(b), .op_select_field_in(sel), .op_immediate_field_in(imm),
      .result(result), .done(done), .busy(busy));
   cfu_cpu_model cpu (.clk(clk), .start(start), .op_a(a), .op_b(b), .sel(sel), .imm(imm),
      .result(result), .done(done));
   always #5 clk = ~clk;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   function automatic logic [31:0] fast_exp(input int s, input logic [31:0] x, y);
      logic [31:0] g;
      g[31] = x[31];
      for (int i = 30; i >= 0; i--) g[i] = g[i+1] ^ x[i];
      case (s)
         0: return 32'(x[7:0]) + 32'(x[15:8]) + 32'(x[23:16]) + 32'(x[31:24]);
         1: return x ^ (x >> 1);
         2: return g;
         default: return (x << y[4:0]) | (x >> (32 - y[4:0]));
      endcase
   endfunction : fast_exp
   task automatic t_fast;
      logic [31:0] v [3] = '{32'h00cafe00, 32'h12345678, 32'hffffffff};
      for (int k = 0; k < 12; k++) begin
         cpu.issue(3'(k % 4), 7'h27, v[k/4], 32'(k * 5), k != 11, r, lat);
         check(r, fast_exp(k % 4, v[k/4], 32'(k * 5)));
         check(32'(lat), 32'h0);
      end
      cpu.issue(3'h3, 7'h0, 32'h80000001, 32'h20, 0, r, lat);
      check(r, 32'h80000001);
      $display("test fast ops done");
   endtask : t_fast
   task automatic t_mac;
      cpu.issue(3'h4, 7'h0, 32'h3, 32'h4, 0, r, lat);
      check(r, 32'hc);
      cpu.issue(3'h4, 7'h1, 32'h2, 32'h5, 0, r, lat);
      check(r, 32'h16);
      cpu.issue(3'h4, 7'h0, 32'h1, 32'h1, 0, r, lat);
      check(r, 32'h1);
      $display("test accumulate done");
   endtask : t_mac
   task automatic t_lut;
      cpu.issue(3'h5, 7'h7f, 32'ha5a5a5a5, 32'h0, 0, r, lat);
      check(32'(lat), 32'h2);
      cpu.issue(3'h5, 7'h7f, 32'h0badf00d, 32'h0, 0, r, lat);
      check(r, 32'ha5a5a5a5);
      cpu.issue(3'h5, 7'h00, 32'h12121212, 32'h0, 1, r, lat);
      cpu.issue(3'h6, 7'h7f, 32'h0, 32'h0, 0, r, lat);
      check(r, 32'h0badf00d);
      check(32'(lat), 32'h2);
      $display("test lookup done");
   endtask : t_lut
   task automatic t_mul;
      cpu.issue(3'h7, 7'h0, 32'h12345678, 32'h9abcdef0, 0, r, lat);
      check(r, 32'h12345678 * 32'h9abcdef0);
      check(32'(lat), 32'h21);
      check(32'(busy), 32'h1);
      @(negedge clk);
      #1;
      check(32'(busy), 32'h0);
      fork
         cpu.issue(3'h7, 7'h0, 32'hffffffff, 32'hffffffff, 0, r, lat);
         begin
            repeat (10) @(negedge clk);
            ce = 1'b0;
            #1;
            check(32'(busy), 32'h1);
            repeat (4) @(negedge clk);
            ce = 1'b1;
         end
      join
      check(r, 32'h1);
      check(32'(lat), 32'h25);
      check(32'(cpu.illegal_seen), 32'h0);
      $display("test multiply done");
   endtask : t_mul
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      #20us;
      fails++;
      report_and_stop();
   end
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      ce = 1'b1;
      repeat (20) @(negedge clk);
      check(result, 32'h0);
      check(32'(done), 32'h0);
      check(32'(busy), 32'h0);
      nrst = 1'b1;
      t_fast();
      t_mac();
      t_lut();
      t_mul();
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
